/* dpm_dev_model.sv */
// Behavioural two-port memory device with token flags and mailbox
`timescale 1ns/1ps
module dpm_dev_model
    import dpm_pkg::*;
#(
    parameter bit LARGE_DEPTH = 1'b0
) (
    input  wire dpm_pkg::dpm_pins_t    pL,
    input  wire dpm_pkg::dpm_pins_t    pR,
    input  wire logic [1:0]            holdBusy,
    output logic [dpm_pkg::DATA_W-1:0] dL,
    output logic [dpm_pkg::DATA_W-1:0] dR,
    output logic [1:0]                 busy_n,
    output logic [1:0]                 int_n
);
    logic [DATA_W-1:0] mem [0:65535];
    logic [1:0]        owner [8];  // 0 free, 1 left, 2 right
    logic [1:0]        pend [8];   // Waiting request per port
    logic [ADDR_W-1:0] top;
    logic [ADDR_W-1:0] nxt;
    // Mailbox words and busy outputs
    assign top = LARGE_DEPTH ? MBX_TOP_LARGE : MBX_TOP_SMALL;
    assign nxt = LARGE_DEPTH ? MBX_NEXT_LARGE : MBX_NEXT_SMALL;
    assign busy_n = ~holdBusy | {1'b0, holdBusy[1]};
    initial begin
        int_n = 2'b11;
        foreach (owner[i]) begin
            owner[i] = 2'b00;
            pend[i] = 2'b00;
        end
    end
    // Read value; lanes not driven show the inverse
    function automatic logic [DATA_W-1:0] rd(input int s, input dpm_pins_t p);
        logic [DATA_W-1:0] v;
        logic [DATA_W-1:0] m;
        v = mem[p.addr];
        m = {{LANE_W{~p.upper_lane_en_n}}, {LANE_W{~p.lower_lane_en_n}}};
        if (!p.token_space_sel_n && (p.chipSel_n || (p.upper_lane_en_n && p.lower_lane_en_n))) begin
            v = {DATA_W{owner[p.addr[2:0]] != s + 1}};
            m = '1;
        end else if (p.chipSel_n) m = '0;
        if (p.outEn_n || !p.rdWr) m = '0;
        return (v & m) | (~v & ~m);
    endfunction : rd
    assign dL = rd(0, pL);
    assign dR = rd(1, pR);
    // Write at end of strobe
    task automatic wr(input int s, input dpm_pins_t p);
        int t;
        t = p.addr[2:0];
        if (!p.token_space_sel_n && (p.chipSel_n || (p.upper_lane_en_n && p.lower_lane_en_n))) begin
            if (!p.dataOut[0] && owner[t] == 2'b00) owner[t] = 2'(s + 1);
            else if (!p.dataOut[0] && owner[t] != s + 1) pend[t][s] = 1'b1;
            else if (p.dataOut[0] && owner[t] == s + 1) begin
                owner[t] = pend[t][1-s] ? 2'(2 - s) : 2'b00;
                pend[t][1-s] = 1'b0;
            end
        end else if (!p.chipSel_n) begin
            if (!p.upper_lane_en_n) mem[p.addr][17:9] = p.dataOut[17:9];
            if (!p.lower_lane_en_n) mem[p.addr][8:0] = p.dataOut[8:0];
            if (busy_n[s] && p.addr == (s ? nxt : top)) int_n[1-s] = 1'b0;
        end
    endtask : wr
    always @(posedge pL.rdWr) wr(0, pL);
    always @(posedge pR.rdWr) wr(1, pR);
    // Mailbox clear on read
    always @* begin
        if (!pR.chipSel_n && !pR.outEn_n && pR.addr == top && busy_n[1]) int_n[1] = 1'b1;
        if (!pL.chipSel_n && !pL.outEn_n && pL.addr == nxt && busy_n[0]) int_n[0] = 1'b1;
    end
endmodule : dpm_dev_model

/* dpm_pkg.sv */
// Shared constants and carrier types for the dual-port memory port controller
package dpm_pkg;
    localparam int ADDR_W      = 16;
    localparam int DATA_W      = 18;
    localparam int LANE_W      = 9;
    localparam int SEL_W       = 3;
    // Mailbox word addresses, small and large depth variants
    localparam logic [ADDR_W-1:0] MBX_TOP_SMALL  = 16'h7fff;
    localparam logic [ADDR_W-1:0] MBX_NEXT_SMALL = 16'h7ffe;
    localparam logic [ADDR_W-1:0] MBX_TOP_LARGE  = 16'hffff;
    localparam logic [ADDR_W-1:0] MBX_NEXT_LARGE = 16'hfffe;
    // Strobe timing at 40 MHz
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETUP_NS      = 25;
    localparam int STROBE_NS     = 25;
    localparam int HOLD_NS       = 25;
    localparam logic [3:0] SETUP_CYC  = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] HOLD_CYC   = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        DPM_RD_MEM, DPM_WR_MEM, DPM_RD_TOKEN, DPM_WR_TOKEN
    } dpm_op_t;

    typedef struct packed {
        dpm_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [1:0]        lanes;   // [1] upper, [0] lower
        logic [DATA_W-1:0] wdata;
    } dpm_req_t;

    // Pins toward one port of the device
    typedef struct packed {
        logic              chipSel_n;
        logic              rdWr;
        logic              outEn_n;
        logic              upper_lane_en_n;
        logic              lower_lane_en_n;
        logic              token_space_sel_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dataOut;
        logic [DATA_W-1:0] dataOe_n;
    } dpm_pins_t;
endpackage : dpm_pkg

/* dpm_port_ctrl.sv */
// Host-side controller driving one port of the dual-port memory
`timescale 1ns/1ps
// What this block does
// - Upper-lane-only write drives upper lane, lower lane stays undriven by host.
// - Lower-lane write drives lower lane; both enables low drives both lanes.
// - Token read: token select low, chip select high, output enable low.
// - Token write puts flag in data bit zero; never token and lane with chip select.
// - Busy input low holds off writes by stretching the write strobe.
module dpm_port_ctrl
    import dpm_pkg::*;
#(
    parameter bit LARGE_DEPTH = 1'b0,
    parameter bit IS_LEFT     = 1'b1
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire dpm_pkg::dpm_req_t req,
    input  wire logic              reqValid,
    output logic                   reqReady,
    output logic [dpm_pkg::DATA_W-1:0] rspData,
    output logic                   rspValid,
    output logic                   tokenHeld,
    output dpm_pkg::dpm_pins_t     pins,
    input  wire logic [dpm_pkg::DATA_W-1:0] dataIn,
    input  wire logic              busy_n,
    input  wire logic              interrupt_n,
    output logic                   mailboxPending
);
    import dpm_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} dpm_state_t;

    typedef struct packed {
        dpm_state_t        state;
        logic [3:0]        cnt;
        dpm_req_t          cur;
        dpm_pins_t         pins;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
        logic              held;
        logic              mbx;
    } dpm_ctrl_t;

    dpm_ctrl_t st, next_st;

    // Lane enables to per-bit data drive mask
    function automatic logic [DATA_W-1:0] laneMask(input logic [1:0] lanes);
        laneMask = {{LANE_W{lanes[1]}}, {LANE_W{lanes[0]}}};
    endfunction : laneMask

    // Idle pin state: deselected, token space off, outputs off
    function automatic dpm_pins_t idlePins();
        dpm_pins_t p;
        p = '0;
        p.chipSel_n         = 1'b1;
        p.rdWr              = 1'b1;
        p.outEn_n           = 1'b1;
        p.upper_lane_en_n   = 1'b1;
        p.lower_lane_en_n   = 1'b1;
        p.token_space_sel_n = 1'b1;
        p.dataOe_n          = '1;
        idlePins = p;
    endfunction : idlePins

    logic [ADDR_W-1:0] ownMbx;
    logic              isWrite;
    // Mailbox word this port reads to clear its own interrupt
    assign ownMbx = IS_LEFT ? (LARGE_DEPTH ? MBX_NEXT_LARGE : MBX_NEXT_SMALL)
                            : (LARGE_DEPTH ? MBX_TOP_LARGE : MBX_TOP_SMALL);
    assign isWrite = (st.cur.op == DPM_WR_MEM) || (st.cur.op == DPM_WR_TOKEN);

    // Sequencer: setup, strobe, hold
    always_comb begin
        next_st        = st;
        next_st.rvalid = 1'b0;
        next_st.mbx    = ~interrupt_n;
        unique case (st.state)
            ST_IDLE: begin
                next_st.pins = idlePins();
                if (reqValid) begin
                    next_st.cur   = req;
                    next_st.cnt   = SETUP_CYC;
                    next_st.state = ST_SETUP;
                    next_st.pins.addr = req.addr;
                    if (req.op == DPM_RD_TOKEN || req.op == DPM_WR_TOKEN) begin
                        // Chip select high so no lane conflict arises
                        next_st.pins.token_space_sel_n = 1'b0;
                        if (req.op == DPM_RD_TOKEN)
                            next_st.pins.outEn_n = 1'b0;
                        else begin
                            next_st.pins.dataOut  = {{(DATA_W-1){1'b0}}, req.wdata[0]};
                            next_st.pins.dataOe_n = '0;
                        end
                    end else begin
                        next_st.pins.chipSel_n       = 1'b0;
                        next_st.pins.upper_lane_en_n = ~req.lanes[1];
                        next_st.pins.lower_lane_en_n = ~req.lanes[0];
                        if (req.op == DPM_WR_MEM) begin
                            next_st.pins.dataOut  = req.wdata;
                            next_st.pins.dataOe_n = ~laneMask(req.lanes);
                        end else
                            next_st.pins.outEn_n  = 1'b0;
                    end
                end
            end
            ST_SETUP: begin
                if (st.cnt > 4'h1)
                    next_st.cnt = st.cnt - 4'h1;
                else begin
                    next_st.cnt   = STROBE_CYC;
                    next_st.state = ST_STROBE;
                    if (isWrite)
                        next_st.pins.rdWr = 1'b0;
                end
            end
            ST_STROBE: begin
                // Slave mode: busy low stretches the write strobe
                if (st.cnt > 4'h1)
                    next_st.cnt = st.cnt - 4'h1;
                else if (!(isWrite && !busy_n)) begin
                    next_st.cnt   = HOLD_CYC;
                    next_st.state = ST_HOLD;
                    next_st.pins.rdWr = 1'b1;
                    if (!isWrite) begin
                        next_st.rdata  = dataIn & ((st.cur.op == DPM_RD_TOKEN) ? '1
                                         : laneMask(st.cur.lanes));
                        next_st.rvalid = 1'b1;
                        if (st.cur.op == DPM_RD_TOKEN)
                            next_st.held = ~dataIn[0];
                    end
                end
            end
            ST_HOLD: begin
                if (st.cnt > 4'h1)
                    next_st.cnt = st.cnt - 4'h1;
                else begin
                    next_st.pins  = idlePins();
                    next_st.state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st        <= '0;
            st.state  <= ST_IDLE;
            st.pins   <= idlePins();
        end else
            st <= next_st;
    end

    assign reqReady       = (st.state == ST_IDLE);
    assign rspData        = st.rdata;
    assign rspValid       = st.rvalid;
    assign tokenHeld      = st.held;
    assign pins           = st.pins;
    assign mailboxPending = st.mbx;

    // Never chip select, token select and a lane enable together
    property p_noTokenLaneMix;
        @(posedge mclk) disable iff (rst)
        !(!pins.chipSel_n && !pins.token_space_sel_n &&
          (!pins.upper_lane_en_n || !pins.lower_lane_en_n));
    endproperty
    a_noTokenLaneMix: assert property (p_noTokenLaneMix) else $error("token and lane mix");

    // Host never drives data while output enable low
    property p_noFight;
        @(posedge mclk) disable iff (rst)
        !pins.outEn_n |-> (pins.dataOe_n == '1);
    endproperty
    a_noFight: assert property (p_noFight) else $error("data contention");

    // Upper-only write leaves lower lane undriven
    property p_upperOnly;
        @(posedge mclk) disable iff (rst)
        (!pins.rdWr && pins.upper_lane_en_n == 1'b0 && pins.lower_lane_en_n)
            |-> (pins.dataOe_n[LANE_W-1:0] == '1);
    endproperty
    a_upperOnly: assert property (p_upperOnly) else $error("lower lane driven");

    // Lower-only write leaves upper lane undriven
    property p_lowerOnly;
        @(posedge mclk) disable iff (rst)
        (!pins.rdWr && pins.lower_lane_en_n == 1'b0 && pins.upper_lane_en_n)
            |-> (pins.dataOe_n[DATA_W-1:LANE_W] == '1);
    endproperty
    a_lowerOnly: assert property (p_lowerOnly) else $error("upper lane driven");

    // Token read keeps chip select high
    property p_tokenRead;
        @(posedge mclk) disable iff (rst)
        (!pins.token_space_sel_n && !pins.outEn_n) |-> pins.chipSel_n;
    endproperty
    a_tokenRead: assert property (p_tokenRead) else $error("token read selects memory");

    // Token write keeps data bits above bit zero at zero
    property p_tokenWrite;
        @(posedge mclk) disable iff (rst)
        (!pins.token_space_sel_n && !pins.rdWr) |-> (pins.dataOut[DATA_W-1:1] == '0);
    endproperty
    a_tokenWrite: assert property (p_tokenWrite) else $error("token write bits");

    // Write strobe held while busy input low
    property p_busyHold;
        @(posedge mclk) disable iff (rst)
        (!pins.rdWr && !busy_n && st.state == ST_STROBE) |=> !pins.rdWr;
    endproperty
    a_busyHold: assert property (p_busyHold) else $error("write ended under busy");

    // Token read result updates held flag
    property p_heldTrack;
        @(posedge mclk) disable iff (rst)
        (rspValid && st.cur.op == DPM_RD_TOKEN) |-> (tokenHeld == ~rspData[0]);
    endproperty
    a_heldTrack: assert property (p_heldTrack) else $error("held flag wrong");

    c_memWrite:   cover property (@(posedge mclk) disable iff (rst) !pins.rdWr && !pins.chipSel_n);
    c_tokenGain:  cover property (@(posedge mclk) disable iff (rst) rspValid && tokenHeld);
    c_busyStall:  cover property (@(posedge mclk) disable iff (rst) !busy_n && !pins.rdWr);
    c_mailbox:    cover property (@(posedge mclk) disable iff (rst)
                                  rspValid && st.cur.addr == ownMbx);
endmodule : dpm_port_ctrl

/* test_dual_port_ram_mailbox_token.sv */
// Self-checking bench: two port controllers around one device model
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_dual_port_ram_mailbox_token;
    import dpm_pkg::*;
    logic              mclk;
    logic              rst;
    dpm_req_t          req [2];
    logic [1:0]        reqValid;
    logic [1:0]        holdBusy;
    wire  [1:0]        reqReady, rspValid, held, mbx, busy_n, int_n;
    wire  [DATA_W-1:0] rsp [2];
    wire  [DATA_W-1:0] din [2];
    wire  dpm_pins_t   pins [2];
    logic [DATA_W-1:0] q;
    int                err_total;
    int                checked;
    dpm_port_ctrl #(.LARGE_DEPTH(1'b0), .IS_LEFT(1'b1)) uut (.mclk(mclk), .rst(rst),
        .req(req[0]), .reqValid(reqValid[0]), .reqReady(reqReady[0]), .rspData(rsp[0]),
        .rspValid(rspValid[0]), .tokenHeld(held[0]), .pins(pins[0]), .dataIn(din[0]),
        .busy_n(busy_n[0]), .interrupt_n(int_n[0]), .mailboxPending(mbx[0]));
    dpm_port_ctrl #(.LARGE_DEPTH(1'b0), .IS_LEFT(1'b0)) uutRight (.mclk(mclk), .rst(rst),
        .req(req[1]), .reqValid(reqValid[1]), .reqReady(reqReady[1]), .rspData(rsp[1]),
        .rspValid(rspValid[1]), .tokenHeld(held[1]), .pins(pins[1]), .dataIn(din[1]),
        .busy_n(busy_n[1]), .interrupt_n(int_n[1]), .mailboxPending(mbx[1]));
    dpm_dev_model #(.LARGE_DEPTH(1'b0)) dev (.pL(pins[0]), .pR(pins[1]),
        .holdBusy(holdBusy), .dL(din[0]), .dR(din[1]), .busy_n(busy_n), .int_n(int_n));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Left writes drive only the enabled lanes
    always @(negedge mclk) begin
        if (!rst && pins[0].rdWr === 1'b0 && pins[0].token_space_sel_n === 1'b1)
            `CHK(pins[0].dataOe_n, {{LANE_W{pins[0].upper_lane_en_n}},
                {LANE_W{pins[0].lower_lane_en_n}}})
    end
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    // One request, waits until the port is idle again
    task automatic xfer(input int s, input dpm_op_t op, input logic [ADDR_W-1:0] a,
                        input logic [1:0] ln, input logic [DATA_W-1:0] d);
        int n;
        q = 'x;
        n = 0;
        @(posedge mclk);
        req[s] <= '{op, a, ln, d};
        reqValid[s] <= 1'b1;
        @(posedge mclk);
        reqValid[s] <= 1'b0;
        do begin
            @(negedge mclk);
            if (rspValid[s] === 1'b1) q = rsp[s];
            n++;
            if (n > 60) begin
                `CHK(n, 60)
                tally_and_finish();
            end
        end while (reqReady[s] !== 1'b1);
    endtask : xfer
    task automatic testLanes();
        xfer(0, DPM_WR_MEM, 16'h0010, 2'b11, {9'h1aa, 9'h055});
        xfer(0, DPM_WR_MEM, 16'h0010, 2'b10, {9'h0cc, 9'h1ff});
        xfer(1, DPM_RD_MEM, 16'h0010, 2'b11, '0);
        `CHK(q, {9'h0cc, 9'h055})
        xfer(0, DPM_WR_MEM, 16'h0010, 2'b01, {9'h1ff, 9'h033});
        xfer(0, DPM_RD_MEM, 16'h0010, 2'b11, '0);
        `CHK(q, {9'h0cc, 9'h033})
        xfer(0, DPM_RD_MEM, 16'h0010, 2'b10, '0);
        `CHK(q, {9'h0cc, 9'h000})
        xfer(1, DPM_RD_MEM, 16'h0010, 2'b01, '0);
        `CHK(q, {9'h000, 9'h033})
        $display("Lane test done");
    endtask : testLanes
    task automatic rdTok(input logic eL, input logic eR);
        for (int s = 0; s < 2; s++) begin
            xfer(s, DPM_RD_TOKEN, 16'h0003, 2'b00, '0);
            `CHK(q[0], s ? eR : eL)
            `CHK(held[s], s ? ~eR : ~eL)
        end
    endtask : rdTok
    task automatic testToken();
        // Rows: port, value written, left readback, right readback
        logic [3:0] seq [11] = '{4'h1, 4'h9, 4'h6, 4'h2, 4'hd, 4'h7, 4'ha, 4'hf, 4'h1, 4'h7, 4'h7};
        rdTok(1'b1, 1'b1);
        for (int i = 0; i < 11; i++) begin
            xfer(seq[i][3], DPM_WR_TOKEN, 16'h0003, 2'b00, {17'h0, seq[i][2]});
            rdTok(seq[i][1], seq[i][0]);
        end
        $display("Token test done");
    endtask : testToken
    task automatic testMailbox();
        xfer(0, DPM_WR_MEM, 16'h7fff, 2'b11, 18'h00001);
        `CHK(mbx, 2'b10)
        xfer(1, DPM_RD_MEM, 16'h0010, 2'b11, '0);
        `CHK(mbx, 2'b10)
        @(posedge mclk) holdBusy <= 2'b10;
        xfer(1, DPM_RD_MEM, 16'h7fff, 2'b11, '0);
        `CHK(mbx, 2'b10)
        @(posedge mclk) holdBusy <= 2'b00;
        xfer(1, DPM_RD_MEM, 16'h7fff, 2'b11, '0);
        `CHK(mbx, 2'b00)
        xfer(1, DPM_WR_MEM, 16'h7ffe, 2'b11, 18'h00002);
        `CHK(mbx, 2'b01)
        @(posedge mclk) holdBusy <= 2'b01;
        xfer(0, DPM_RD_MEM, 16'h7ffe, 2'b11, '0);
        `CHK(mbx, 2'b01)
        @(posedge mclk) holdBusy <= 2'b00;
        xfer(0, DPM_RD_MEM, 16'h7ffe, 2'b11, '0);
        `CHK(mbx, 2'b00)
        $display("Mailbox test done");
    endtask : testMailbox
    task automatic testBusyWrite();
        @(posedge mclk) holdBusy <= 2'b11;
        fork
            xfer(1, DPM_WR_MEM, 16'h0020, 2'b11, 18'h3c3c3);
            begin
                repeat (8) @(negedge mclk);
                `CHK(pins[1].rdWr, 1'b0)
                @(posedge mclk) holdBusy <= 2'b00;
            end
        join
        xfer(0, DPM_RD_MEM, 16'h0020, 2'b11, '0);
        `CHK(q, 18'h3c3c3)
        $display("Busy write test done");
    endtask : testBusyWrite
    // Both ports ask for one token in the same cycle
    task automatic testContend();
        fork
            xfer(0, DPM_WR_TOKEN, 16'h0003, 2'b00, '0);
            xfer(1, DPM_WR_TOKEN, 16'h0003, 2'b00, '0);
        join
        xfer(0, DPM_RD_TOKEN, 16'h0003, 2'b00, '0);
        xfer(1, DPM_RD_TOKEN, 16'h0003, 2'b00, '0);
        `CHK(^held, 1'b1)
        xfer(0, DPM_WR_TOKEN, 16'h0003, 2'b00, 18'h00001);
        xfer(1, DPM_WR_TOKEN, 16'h0003, 2'b00, 18'h00001);
        xfer(0, DPM_WR_TOKEN, 16'h0003, 2'b00, 18'h00001);
        rdTok(1'b1, 1'b1);
        $display("Contention test done");
    endtask : testContend
    // Host reset mid-run while the device keeps the token
    task automatic testReset();
        xfer(0, DPM_WR_TOKEN, 16'h0003, 2'b00, '0);
        xfer(0, DPM_RD_TOKEN, 16'h0003, 2'b00, '0);
        `CHK(held, 2'b01)
        @(posedge mclk) rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        `CHK({held, reqReady, rspValid, pins[0].outEn_n, pins[1].chipSel_n}, 8'h33)
        rdTok(1'b0, 1'b1);
        xfer(0, DPM_WR_TOKEN, 16'h0003, 2'b00, 18'h00001);
        rdTok(1'b1, 1'b1);
        $display("Reset test done");
    endtask : testReset
    initial begin
        rst = 1'b1;
        reqValid = '0;
        holdBusy = '0;
        req[0] = '0;
        req[1] = '0;
        err_total = 0;
        checked = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        testLanes();
        testToken();
        testMailbox();
        testBusyWrite();
        testContend();
        testReset();
        tally_and_finish();
    end
endmodule : test_dual_port_ram_mailbox_token
